// File: ccd_channel_clock_divider.v
// three-channel output clock divider block with its register file
`timescale 1ns/1ps
`include "ccd_consts.vh"
module ccd_channel_clock_divider #(
  parameter NCH = 3
) (
  input  wire           clk,
  input  wire           rst,
  input  wire           divInEn,
  input  wire           syncIn,
  input  wire           oscIn,
  input  wire           extClkIn,
  input  wire [1:0]     sourceSelect,
  input  wire [9:0]     regAddr,
  input  wire [7:0]     regWrData,
  input  wire           regWrEn,
  output reg  [7:0]     regRdData,
  output reg  [3*NCH-1:0] chanOut,
  output reg  [3*NCH-1:0] chanPowerDown,
  output reg  [NCH-1:0] dutyCycleCorrectionEn
);
  // pin inputs pass two flops before use
  reg  [1:0] syncMeta_reg;
  reg  [1:0] oscMeta_reg;
  reg  [1:0] extMeta_reg;
  reg  [1:0] tickMeta_reg;
  reg  [1:0] src_reg0;
  reg  [1:0] src_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      syncMeta_reg <= 2'h0;
      oscMeta_reg  <= 2'h0;
      extMeta_reg  <= 2'h0;
      tickMeta_reg <= 2'h0;
      src_reg0     <= 2'h0;
      src_reg      <= 2'h0;
    end else begin
      syncMeta_reg <= {syncMeta_reg[0], syncIn};
      oscMeta_reg  <= {oscMeta_reg[0], oscIn};
      extMeta_reg  <= {extMeta_reg[0], extClkIn};
      tickMeta_reg <= {tickMeta_reg[0], divInEn};
      src_reg0     <= sourceSelect;
      src_reg      <= src_reg0;
    end
  end
  wire syncS = syncMeta_reg[1];
  wire oscS  = oscMeta_reg[1];
  wire extS  = extMeta_reg[1];
  wire tickS = tickMeta_reg[1];

  reg  [7:0] counts_reg [0:NCH-1];
  reg  [7:0] ctrl_reg   [0:NCH-1];
  reg  [7:0] pwr_reg    [0:NCH-1];
  reg  [7:0] rdNext;
  integer    k;
  // separate loop index: one variable per process
  integer    j;

  // registers: three bytes per channel from the channel 0 base
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      counts_reg[0] <= `CCD_RST_CH0_COUNTS;
      counts_reg[1] <= `CCD_RST_CH1_COUNTS;
      counts_reg[2] <= `CCD_RST_CH2_COUNTS;
      for (k = 0; k < NCH; k = k + 1) begin
        ctrl_reg[k] <= `CCD_RST_CTRL;
        pwr_reg[k]  <= `CCD_RST_PWR;
      end
    end else if (regWrEn) begin
      for (k = 0; k < NCH; k = k + 1) begin
        if (regAddr == `CCD_ADDR_CH0_COUNTS + 3 * k) begin
          counts_reg[k] <= regWrData;
        end
        if (regAddr == `CCD_ADDR_CH0_CTRL + 3 * k) begin
          ctrl_reg[k] <= regWrData;
        end
        if (regAddr == `CCD_ADDR_CH0_PWR + 3 * k) begin
          // unused bits 7:3 stay zero
          pwr_reg[k] <= regWrData & `CCD_PWR_MASK;
        end
      end
    end
  end

  always @* begin
    rdNext = 8'h00;
    for (j = 0; j < NCH; j = j + 1) begin
      if (regAddr == `CCD_ADDR_CH0_COUNTS + 3 * j) begin
        rdNext = counts_reg[j];
      end
      if (regAddr == `CCD_ADDR_CH0_CTRL + 3 * j) begin
        rdNext = ctrl_reg[j];
      end
      if (regAddr == `CCD_ADDR_CH0_PWR + 3 * j) begin
        rdNext = pwr_reg[j];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= rdNext;
    end
  end

  // input clock seen by bypassed channels as a level: enable pulse toggles it
  reg divInLevel_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      divInLevel_reg <= 1'b0;
    end else if (tickS) begin
      divInLevel_reg <= ~divInLevel_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gCh
      wire [7:0] ctrl   = ctrl_reg[g];
      wire [7:0] pwr    = pwr_reg[g];
      wire       bypass = ctrl[`CCD_BIT_BYPASS];
      wire       forced = ctrl[`CCD_BIT_IGNSYNC] & ctrl[`CCD_BIT_FORCE];
      wire       divOut;
      reg        divSel;
      reg        outNext;
      ccd_divider u_div (
        .clk    (clk),
        .rst    (rst),
        // bypass holds the counter still, standing in for its power-down
        .tickEn (tickS & ~bypass),
        .syncIn (syncS),
        .counts (counts_reg[g]),
        .ctrl   (ctrl),
        .divOut (divOut)
      );
      always @* begin
        if (bypass) begin
          divSel = divInLevel_reg;
        end else if (forced) begin
          divSel = ctrl[`CCD_BIT_STARTHI];
        end else begin
          divSel = divOut;
        end
        outNext = divSel;
        if (pwr[`CCD_BIT_DIRECT]) begin
          case (src_reg)
            `CCD_SRC_OSC:  outNext = oscS;
            `CCD_SRC_EXT:  outNext = extS;
            `CCD_SRC_NONE: outNext = divSel;
            default:       outNext = divSel;
          endcase
        end
        if (pwr[`CCD_BIT_PWRDN]) begin
          outNext = 1'b0;
        end
      end
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          chanOut[3*g+2:3*g]       <= 3'h0;
          chanPowerDown[3*g+2:3*g] <= 3'h0;
          dutyCycleCorrectionEn[g] <= 1'b1;
        end else begin
          chanOut[3*g+2:3*g]       <= {3{outNext}};
          chanPowerDown[3*g+2:3*g] <= {3{pwr[`CCD_BIT_PWRDN]}};
          dutyCycleCorrectionEn[g] <= ~pwr[`CCD_BIT_DCCOFF];
        end
      end
    end
  endgenerate
endmodule // ccd_channel_clock_divider

// File: ccd_consts.vh
// register offsets, field positions, reset values for channel dividers
`ifndef CCD_CONSTS_VH
`define CCD_CONSTS_VH
`define CCD_ADDR_CH0_COUNTS   10'h190
`define CCD_ADDR_CH0_CTRL     10'h191
`define CCD_ADDR_CH0_PWR      10'h192
`define CCD_ADDR_CH1_COUNTS   10'h193
`define CCD_ADDR_CH1_CTRL     10'h194
`define CCD_ADDR_CH1_PWR      10'h195
`define CCD_ADDR_CH2_COUNTS   10'h196
`define CCD_ADDR_CH2_CTRL     10'h197
`define CCD_ADDR_CH2_PWR      10'h198
`define CCD_RST_CH0_COUNTS    8'h77
`define CCD_RST_CH1_COUNTS    8'h33
`define CCD_RST_CH2_COUNTS    8'h11
`define CCD_RST_CTRL          8'h00
`define CCD_RST_PWR           8'h00
`define CCD_BIT_BYPASS        7
`define CCD_BIT_IGNSYNC       6
`define CCD_BIT_FORCE         5
`define CCD_BIT_STARTHI       4
`define CCD_BIT_PWRDN         2
`define CCD_BIT_DIRECT        1
`define CCD_BIT_DCCOFF        0
`define CCD_PWR_MASK          8'h07
`define CCD_SRC_OSC           2'h2
`define CCD_SRC_EXT           2'h0
`define CCD_SRC_NONE          2'h1
`endif

// File: ccd_divider.v
// one channel divider: low/high counts, start level, phase offset, sync
`timescale 1ns/1ps
`include "ccd_consts.vh"
module ccd_divider (
  input  wire       clk,
  input  wire       rst,
  input  wire       tickEn,
  input  wire       syncIn,
  input  wire [7:0] counts,
  input  wire [7:0] ctrl,
  output reg        divOut
);
  reg  [3:0] cnt_reg;
  reg  [3:0] phase_reg;
  reg        syncPrev_reg;
  wire       ignoreSync = ctrl[`CCD_BIT_IGNSYNC];
  wire       startHigh  = ctrl[`CCD_BIT_STARTHI];
  wire       syncRise   = syncIn & ~syncPrev_reg & ~ignoreSync;
  wire [3:0] halfLen    = divOut ? counts[3:0] : counts[7:4];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg      <= 4'h0;
      phase_reg    <= 4'h0;
      divOut       <= 1'b0;
      syncPrev_reg <= 1'b0;
    end else begin
      syncPrev_reg <= syncIn;
      if (syncRise) begin
        // restart at start level, then wait out the phase offset
        divOut    <= startHigh;
        cnt_reg   <= 4'h0;
        phase_reg <= ctrl[3:0];
      end else if (tickEn) begin
        if (phase_reg != 4'h0) begin
          phase_reg <= phase_reg - 4'h1;
        end else if (cnt_reg >= halfLen) begin
          // counts compared on every tick, so a new value takes effect within the current half
          cnt_reg <= 4'h0;
          divOut  <= ~divOut;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule // ccd_divider

// File: ccd_channel_clock_divider_properties.sv
// port checks of the channel divider block
`timescale 1ns/1ps
`include "ccd_consts.vh"
module ccd_cdiv_props #(
  parameter NCH = 3
) (
  input wire             clk,
  input wire             rst,
  input wire [9:0]       regAddr,
  input wire [7:0]       regWrData,
  input wire             regWrEn,
  input wire [7:0]       regRdData,
  input wire [3*NCH-1:0] chanOut,
  input wire [3*NCH-1:0] chanPowerDown,
  input wire [NCH-1:0]   dutyCycleCorrectionEn
);
  localparam [9:0] APWR = `CCD_ADDR_CH1_PWR;
  localparam [9:0] ACTL = `CCD_ADDR_CH1_CTRL;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_set(b); regWrEn && regAddr == APWR && regWrData[b]; endsequence
  sequence s_clr(b); regWrEn && regAddr == APWR && !regWrData[b]; endsequence
  sequence s_wrrd; regWrEn && regAddr == ACTL ##1 !regWrEn && regAddr == ACTL; endsequence
  property p_pd_on; s_set(2) |-> ##[1:3] chanPowerDown[5:3] == 3'h7; endproperty
  property p_pd_off; s_clr(2) |-> ##[1:3] chanPowerDown[5:3] == 3'h0; endproperty
  property p_dcc_off; s_set(0) |-> ##[1:3] !dutyCycleCorrectionEn[1]; endproperty
  property p_dcc_on; s_clr(0) |-> ##[1:3] dutyCycleCorrectionEn[1]; endproperty
  property p_rdback; s_wrrd |=> regRdData == $past(regWrData, 2); endproperty
  property p_pd_grp; chanPowerDown[5:3] == 3'h0 || chanPowerDown[5:3] == 3'h7; endproperty
  property p_out_grp; chanOut[2:0] == 3'h0 || chanOut[2:0] == 3'h7; endproperty
  // one stable cycle first: both outputs are registered
  property p_pd_zero;
    $stable(chanPowerDown[5:3]) && chanPowerDown[5:3] == 3'h7 |-> chanOut[5:3] == 3'h0;
  endproperty
  a_pd_on: assert property (p_pd_on) else $error("power-down not applied");
  a_pd_off: assert property (p_pd_off) else $error("power-down not lifted");
  a_dcc_off: assert property (p_dcc_off) else $error("correction not disabled");
  a_dcc_on: assert property (p_dcc_on) else $error("correction not enabled");
  a_rdback: assert property (p_rdback) else $error("control byte readback wrong");
  a_pd_grp: assert property (p_pd_grp) else $error("group power-down split");
  a_out_grp: assert property (p_out_grp) else $error("group outputs differ");
  a_pd_zero: assert property (p_pd_zero) else $error("powered-down output active");
endmodule // ccd_cdiv_props

// File: ccd_channel_clock_divider_tb.sv
// self-checking bench of the channel divider block
`timescale 1ns/1ps
`include "ccd_consts.vh"
module ccd_channel_clock_divider_tb;
  reg        clk = 1'b0, rst = 1'b1, divInEn = 1'b0, syncIn = 1'b0;
  reg        oscIn = 1'b0, extClkIn = 1'b0, regWrEn = 1'b0;
  reg  [1:0] sourceSelect = 2'h1;
  reg  [9:0] regAddr = 10'h000;
  reg  [7:0] regWrData = 8'h00, e;
  wire [7:0] regRdData;
  wire [8:0] chanOut, chanPowerDown;
  wire [2:0] dutyCycleCorrectionEn;
  integer    n_errors = 0, compares = 0, i, k, hi, lo, n;
  ccd_channel_clock_divider #(.NCH(3)) dut (.clk(clk), .rst(rst), .divInEn(divInEn),
    .syncIn(syncIn), .oscIn(oscIn), .extClkIn(extClkIn), .sourceSelect(sourceSelect),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData),
    .chanOut(chanOut), .chanPowerDown(chanPowerDown),
    .dutyCycleCorrectionEn(dutyCycleCorrectionEn));
  always #2.5 clk = ~clk;
  // one divider tick every two cycles, pulse or level reading alike
  always @(posedge clk) divInEn <= ~divInEn;
  task complete_run;
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task wr(input [9:0] a, input [7:0] d);
    @(posedge clk) regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk) regWrEn <= 1'b0;
  endtask
  task rd(input [9:0] a, input [7:0] x);
    @(posedge clk) regAddr <= a;
    repeat (2) @(negedge clk);
    chk("regRdData", regRdData, x);
  endtask
  // bounded: a stuck output ends the run
  task halves(input integer b);
    n = 0;
    hi = 0;
    lo = 0;
    while (chanOut[b] !== 1'b0 && n < 200) begin @(negedge clk); n = n + 1; end
    while (chanOut[b] !== 1'b1 && n < 200) begin @(negedge clk); n = n + 1; end
    while (chanOut[b] === 1'b1 && n < 200) begin @(negedge clk); n = n + 1; hi = hi + 1; end
    while (chanOut[b] === 1'b0 && n < 200) begin @(negedge clk); n = n + 1; lo = lo + 1; end
    if (n >= 200) begin
      n_errors = n_errors + 1;
      complete_run;
    end
  endtask
  task sync_pulse;
    @(posedge clk) syncIn <= 1'b1;
    repeat (4) @(posedge clk);
    syncIn <= 1'b0;
    repeat (8) @(negedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 9; i = i + 1) begin
      e = (i == 0) ? 8'h77 : (i == 3) ? 8'h33 : (i == 6) ? 8'h11 : 8'h00;
      rd(`CCD_ADDR_CH0_COUNTS + i[9:0], e);
    end
    chk("dcc", dutyCycleCorrectionEn, 3'h7);
    halves(6);
    chk("ch2 high", hi, 32'h4);
    chk("ch2 low", lo, 32'h4);
    halves(0);
    chk("ch0 period", hi + lo, 32'h20);
    wr(`CCD_ADDR_CH1_COUNTS, 8'h21);
    halves(3);
    chk("ch1 high", hi, 32'h4);
    chk("ch1 low", lo, 32'h6);
    wr(`CCD_ADDR_CH1_PWR, 8'hFD);
    rd(`CCD_ADDR_CH1_PWR, 8'h05);
    chk("pd", {chanPowerDown[5:3], chanOut[5:3], dutyCycleCorrectionEn[1]}, 7'h70);
    wr(`CCD_ADDR_CH1_PWR, 8'h00);
    rd(`CCD_ADDR_CH1_PWR, 8'h00);
    chk("pd off", {chanPowerDown[5:3], dutyCycleCorrectionEn[1]}, 4'h1);
    for (k = 0; k < 3; k = k + 1) begin
      e = (k == 0) ? 8'h60 : (k == 1) ? 8'h70 : 8'hF0;
      wr(`CCD_ADDR_CH1_CTRL, e);
      repeat (8) @(negedge clk);
      lo = chanOut[3];
      n = 0;
      repeat (32) begin @(negedge clk); n = n + (chanOut[3] !== lo[0]); lo = chanOut[3]; end
      chk("toggles", e[7] ? (n >= 15) : (n == 0), 32'h1);
      if (!e[7]) chk("forced level", chanOut[3], e[4]);
    end
    wr(`CCD_ADDR_CH1_CTRL, 8'h0A);
    rd(`CCD_ADDR_CH1_CTRL, 8'h0A);
    wr(`CCD_ADDR_CH1_COUNTS, 8'hFF);
    for (k = 0; k < 3; k = k + 1) begin
      e = (k == 0) ? 8'h10 : (k == 1) ? 8'h40 : 8'h00;
      wr(`CCD_ADDR_CH1_CTRL, e);
      sync_pulse;
      chk("start level", chanOut[3], k < 2);
    end
    wr(`CCD_ADDR_CH0_CTRL, 8'h60);
    wr(`CCD_ADDR_CH0_PWR, 8'h02);
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge clk) oscIn <= i[0];
      extClkIn <= ~i[0];
      sourceSelect <= (i < 2) ? 2'h2 : (i < 4) ? 2'h0 : 2'h1;
      repeat (8) @(negedge clk);
      e = (i < 2) ? {8{i[0]}} : (i < 4) ? {8{~i[0]}} : 8'h00;
      chk("direct", chanOut[2:0], e[2:0]);
    end
    complete_run;
  end
endmodule // ccd_channel_clock_divider_tb
bind ccd_channel_clock_divider ccd_cdiv_props #(.NCH(NCH)) u_props (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData),
  .chanOut(chanOut), .chanPowerDown(chanPowerDown),
  .dutyCycleCorrectionEn(dutyCycleCorrectionEn));
